/* rtl/arfb_frame_builder.v */
// Builds command answer and unsolicited status frames onto a byte stream.
`timescale 1ns/100ps
`include "arfb_defines.vh"
module arfb_frame_builder #(
    parameter AW = 4
) (
    // Clock and reset.
    input  wire          clk_sys_in,
    input  wire          srst_in,
    // Parameter data loading for query answers.
    input  wire          pdata_wr_in,
    input  wire [AW-1:0] pdata_addr_in,
    input  wire [7:0]    pdata_in,
    // Command answer request.
    input  wire          cmd_req_in,
    input  wire [7:0]    cmd_id_in,
    input  wire [7:0]    cmd_name0_in,
    input  wire [7:0]    cmd_name1_in,
    input  wire [7:0]    cmd_status_in,
    input  wire          cmd_query_in,
    input  wire [AW:0]   cmd_dlen_in,
    output reg           cmd_busy_out,
    // Unsolicited status event.
    input  wire          stat_req_in,
    input  wire [7:0]    stat_code_in,
    output reg           stat_pend_out,
    // Byte stream toward the serial port.
    output reg  [7:0]    tx_data_out,
    output reg           tx_valid_out,
    output reg           tx_last_out,
    input  wire          tx_ready_in
);
    // One-hot states: idle, header bytes, parameter bytes, checksum.
    localparam [3:0] ST_IDLE = 4'b0001;
    localparam [3:0] ST_HEAD = 4'b0010;
    localparam [3:0] ST_DATA = 4'b0100;
    localparam [3:0] ST_CKS  = 4'b1000;

    reg [3:0]    state_r;
    reg [2:0]    idx_r;
    reg          is_cmd_r;
    reg [7:0]    id_r;
    reg [7:0]    n0_r;
    reg [7:0]    n1_r;
    reg [7:0]    st_r;
    reg [7:0]    cmd_st_r;
    reg [AW:0]   dlen_r;
    reg [AW:0]   didx_r;
    reg [7:0]    sum_r;
    reg          cmd_pend_r;
    reg [7:0]    scode_r;
    reg          fetch_r;
    reg [15:0]   len_w;
    reg [7:0]    hdr_w;
    reg [2:0]    hdr_last_w;
    wire [7:0]   mem_q;
    wire         take_w;

    // Answer data are read from address zero upward, one byte per fetch.
    arfb_data_mem #(.AW(AW)) u_mem (
        .clk_sys_in (clk_sys_in),
        .wr_en_in   (pdata_wr_in),
        .wr_addr_in (pdata_addr_in),
        .wr_data_in (pdata_in),
        .rd_addr_in (didx_r[AW-1:0]),
        .rd_data_out(mem_q)
    );

    // A byte leaves when the consumer takes it; a byte not taken stays on the port.
    assign take_w = tx_valid_out & tx_ready_in;

    always @*
    begin
        // Length counts type through last data byte.
        len_w = is_cmd_r ? (`ARFB_CMD_FIXED + {{(15-AW){1'b0}}, dlen_r}) : `ARFB_STAT_LEN;
        hdr_last_w = is_cmd_r ? 3'h7 : 3'h4;
        case (idx_r)
            3'h0: hdr_w = `ARFB_DELIM;
            3'h1: hdr_w = len_w[15:8];
            3'h2: hdr_w = len_w[7:0];
            3'h3: hdr_w = is_cmd_r ? `ARFB_TYPE_CMD : `ARFB_TYPE_STAT;
            // Offset 4 holds the identifier of an answer or the code of an event.
            3'h4: hdr_w = is_cmd_r ? id_r : st_r;
            3'h5: hdr_w = n0_r;
            3'h6: hdr_w = n1_r;
            3'h7: hdr_w = cmd_st_r;
            default: hdr_w = 8'h00;
        endcase
    end

    always @(posedge clk_sys_in)
    begin
        if (srst_in)
        begin
            state_r       <= ST_IDLE;
            idx_r         <= 3'h0;
            is_cmd_r      <= 1'b0;
            id_r          <= 8'h00;
            n0_r          <= 8'h00;
            n1_r          <= 8'h00;
            st_r          <= 8'h00;
            cmd_st_r      <= 8'h00;
            dlen_r        <= {(AW+1){1'b0}};
            didx_r        <= {(AW+1){1'b0}};
            sum_r         <= 8'h00;
            cmd_pend_r    <= 1'b0;
            scode_r       <= 8'h00;
            fetch_r       <= 1'b0;
            cmd_busy_out  <= 1'b0;
            stat_pend_out <= 1'b0;
            tx_data_out   <= 8'h00;
            tx_valid_out  <= 1'b0;
            tx_last_out   <= 1'b0;
        end
        else
        begin
            // A request while busy is dropped without a trace; callers watch busy.
            // Latch a command answer; identifier zero asks for silence.
            if (cmd_req_in && !cmd_busy_out && cmd_id_in != 8'h00)
            begin
                cmd_busy_out <= 1'b1;
                cmd_pend_r   <= 1'b1;
                id_r         <= cmd_id_in;
                n0_r         <= cmd_name0_in;
                n1_r         <= cmd_name1_in;
                // Kept apart from the event code, so that an event frame sent
                // while the answer waits cannot corrupt its status byte.
                cmd_st_r     <= cmd_status_in;
                // Set answers carry no data even if a length is offered.
                dlen_r <= cmd_query_in ? cmd_dlen_in : {(AW+1){1'b0}};
            end
            // A new event while one waits overwrites the code; only one is held.
            if (stat_req_in)
            begin
                stat_pend_out <= 1'b1;
                scode_r       <= stat_code_in;
            end
            case (state_r)
                ST_IDLE:
                begin
                    // The checksum byte of the last frame may still wait for the
                    // consumer; no new frame starts before it has been taken.
                    if (take_w)
                    begin
                        tx_valid_out <= 1'b0;
                        tx_last_out  <= 1'b0;
                    end
                    // Status events go first, as they are rarer and time sensitive, unless stat_req_in is high in that cycle.
                    if (!tx_valid_out || take_w)
                    begin
                        if (stat_pend_out && !stat_req_in)
                        begin
                            is_cmd_r      <= 1'b0;
                            st_r          <= scode_r;
                            stat_pend_out <= 1'b0;
                            idx_r         <= 3'h0;
                            state_r       <= ST_HEAD;
                        end
                        else if (cmd_pend_r)
                        begin
                            is_cmd_r   <= 1'b1;
                            cmd_pend_r <= 1'b0;
                            idx_r      <= 3'h0;
                            state_r    <= ST_HEAD;
                        end
                    end
                end
                ST_HEAD:
                begin
                    if (!tx_valid_out || take_w)
                    begin
                        tx_valid_out <= 1'b1;
                        tx_data_out  <= hdr_w;
                        // Bytes from offset 3 on feed the sum; the first three clear it.
                        sum_r <= (idx_r >= 3'h3) ? sum_r + hdr_w : 8'h00;
                        if (idx_r == hdr_last_w)
                        begin
                            didx_r  <= {(AW+1){1'b0}};
                            fetch_r <= 1'b0;
                            state_r <= (is_cmd_r && dlen_r != {(AW+1){1'b0}}) ?
                                       ST_DATA : ST_CKS;
                        end
                        else
                            idx_r <= idx_r + 3'h1;
                    end
                end
                ST_DATA:
                begin
                    // One idle cycle lets the registered memory read settle.
                    // Data bytes thus leave at most every other cycle, which the
                    // far slower serial port never notices.
                    if (take_w)
                        tx_valid_out <= 1'b0;
                    if (!fetch_r)
                        fetch_r <= 1'b1;
                    else if (!tx_valid_out || take_w)
                    begin
                        tx_valid_out <= 1'b1;
                        tx_data_out  <= mem_q;
                        sum_r        <= sum_r + mem_q;
                        fetch_r      <= 1'b0;
                        didx_r       <= didx_r + 1'b1;
                        if (didx_r + 1'b1 == dlen_r)
                            state_r <= ST_CKS;
                    end
                end
                ST_CKS:
                begin
                    if (!tx_valid_out || take_w)
                    begin
                        // The sum already holds the final byte before the checksum.
                        tx_data_out  <= `ARFB_CKS_BASE - sum_r;
                        tx_valid_out <= 1'b1;
                        tx_last_out  <= 1'b1;
                        state_r      <= ST_IDLE;
                        // Holding busy until the checksum goes lets a caller
                        // chain several answers under one identifier.
                        if (is_cmd_r)
                            cmd_busy_out <= 1'b0;
                    end
                end
                default:
                    state_r <= ST_IDLE;
            endcase
        end
    end
endmodule

/* rtl/arfb_defines.vh */
// Constants for the response frame builder.
`ifndef ARFB_DEFINES_VH
`define ARFB_DEFINES_VH
`define ARFB_DELIM        8'h7E
`define ARFB_TYPE_CMD     8'h88
`define ARFB_TYPE_STAT    8'h8A
`define ARFB_CKS_BASE     8'hFF
`define ARFB_CMD_FIXED    16'h0005
`define ARFB_STAT_LEN     16'h0002
`define ARFB_CST_OK       8'h00
`define ARFB_CST_ERROR    8'h01
`define ARFB_CST_BADCMD   8'h02
`define ARFB_CST_BADPARM  8'h03
`define ARFB_CST_TXFAIL   8'h04
`define ARFB_MS_HWRST     8'h00
`define ARFB_MS_WDRST     8'h01
`define ARFB_MS_JOINED    8'h02
`define ARFB_MS_DISASSOC  8'h03
`define ARFB_MS_COORD     8'h06
`define ARFB_MS_KEYUPD    8'h07
`define ARFB_MS_VSUPPLY   8'h0D
`define ARFB_MS_CFGJOIN   8'h11
`define ARFB_MS_STACKERR  8'h80
`endif

/* rtl/arfb_data_mem.v */
// Parameter data store for query answers, registered read port.
`timescale 1ns/100ps
module arfb_data_mem #(
    parameter AW = 4
) (
    // Clock.
    input  wire          clk_sys_in,
    // Write port.
    input  wire          wr_en_in,
    input  wire [AW-1:0] wr_addr_in,
    input  wire [7:0]    wr_data_in,
    // Read port.
    input  wire [AW-1:0] rd_addr_in,
    output reg  [7:0]    rd_data_out
);
    reg [7:0] mem_r [0:(1<<AW)-1];

    always @(posedge clk_sys_in)
    begin
        if (wr_en_in)
            mem_r[wr_addr_in] <= wr_data_in;
        rd_data_out <= mem_r[rd_addr_in];
    end
endmodule

/* tb/arfb_fb_assertions.sv */
// Port checks on the response frame builder.
`timescale 1ns/100ps
module arfb_fb_checker (
    input wire       clk_sys_in,
    input wire       srst_in,
    input wire       cmd_req_in,
    input wire [7:0] cmd_id_in,
    input wire       cmd_busy_out,
    input wire       stat_req_in,
    input wire       stat_pend_out,
    input wire [7:0] tx_data_out,
    input wire       tx_valid_out,
    input wire       tx_last_out,
    input wire       tx_ready_in
);
    // Offset and running sum of the frame on the wire; cleared after each checksum.
    reg  [4:0] pos_r;
    reg  [7:0] sum_r;
    wire       tk  = tx_valid_out && tx_ready_in;
    wire       clr = srst_in || (tk && tx_last_out);
    always @(posedge clk_sys_in)
    begin
        pos_r <= clr ? 5'h00 : pos_r + {4'h0, tk};
        sum_r <= clr ? 8'h00 : (tk && pos_r > 5'h02) ? sum_r + tx_data_out : sum_r;
    end
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (srst_in);
    chk_stream_hold: assert property (tx_valid_out && !tx_ready_in |=> tx_valid_out &&
        $stable(tx_data_out) && $stable(tx_last_out)) else $error("byte changed in stall");
    chk_frame_delim: assert property (tx_valid_out && pos_r == 5'h00 |->
        tx_data_out == 8'h7E) else $error("frame opened without delimiter");
    chk_frame_type: assert property (tx_valid_out && pos_r == 5'h03 |->
        tx_data_out == 8'h88 || tx_data_out == 8'h8A) else $error("bad frame type");
    chk_frame_sum: assert property (tx_valid_out && tx_last_out |->
        tx_data_out == 8'hFF - sum_r) else $error("bad checksum");
    chk_busy_take: assert property (cmd_req_in && !cmd_busy_out && cmd_id_in != 8'h00
        |=> cmd_busy_out) else $error("request not taken");
    chk_id_zero: assert property (cmd_req_in && !cmd_busy_out && cmd_id_in == 8'h00
        |=> !cmd_busy_out) else $error("zero id taken");
    chk_stat_pend: assert property (stat_req_in |=> stat_pend_out)
        else $error("status event lost");
    chk_last_gap: assert property (tk && tx_last_out |=> !tx_valid_out)
        else $error("no gap after checksum");
    cover property (tx_valid_out && pos_r == 5'h03 && tx_data_out == 8'h88);
    cover property (tx_valid_out && pos_r == 5'h03 && tx_data_out == 8'h8A);
    cover property (tx_valid_out && !tx_ready_in);
endmodule
bind arfb_frame_builder arfb_fb_checker u_chk (.clk_sys_in, .srst_in, .cmd_req_in,
    .cmd_id_in, .cmd_busy_out, .stat_req_in, .stat_pend_out, .tx_data_out,
    .tx_valid_out, .tx_last_out, .tx_ready_in);

/* tb/arfb_host_model.sv */
// Host side of the serial port: takes the byte stream and keeps it.
`timescale 1ns/100ps
module arfb_host_model (
    // Clock.
    input  wire       clk_sys_in,
    // Stream from the builder.
    input  wire [7:0] tx_data_in,
    input  wire       tx_valid_in,
    input  wire       tx_last_in,
    output reg        tx_ready_out,
    // A slow host accepts one cycle in three.
    input  wire       slow_in
);
    reg [7:0] rx_q[$];
    reg       last_q[$];
    reg [1:0] ph_r = 2'h0;
    initial tx_ready_out = 1'b1;
    always @(posedge clk_sys_in)
    begin
        // Unknown codes and repeated identifiers are stored like any other.
        if (tx_valid_in && tx_ready_out)
        begin
            rx_q.push_back(tx_data_in);
            last_q.push_back(tx_last_in);
        end
        ph_r <= (ph_r == 2'h2) ? 2'h0 : ph_r + 2'h1;
        tx_ready_out <= #1 !slow_in || (ph_r == 2'h1);
    end
endmodule

/* tb/api_response_frame_builder_bench.sv */
// Self-checking bench for the response frame builder.
`timescale 1ns/100ps
module api_response_frame_builder_bench;
    reg        clk_sys_in = 1'b0;
    reg        srst_in = 1'b1;
    reg        pdata_wr_in = 1'b0;
    reg  [3:0] pdata_addr_in = 4'h0;
    reg  [7:0] pdata_in = 8'h00;
    reg        cmd_req_in = 1'b0;
    reg  [7:0] cmd_id_in = 8'h00;
    reg  [7:0] cmd_name0_in = 8'h42;
    reg  [7:0] cmd_name1_in = 8'h44;
    reg  [7:0] cmd_status_in = 8'h00;
    reg        cmd_query_in = 1'b0;
    reg  [4:0] cmd_dlen_in = 5'h00;
    reg        stat_req_in = 1'b0;
    reg  [7:0] stat_code_in = 8'h00;
    reg        slow = 1'b0;
    wire       cmd_busy_out, stat_pend_out, tx_valid_out, tx_last_out, tx_ready_in;
    wire [7:0] tx_data_out;
    integer    fails = 0;
    integer    cmp_count = 0;
    integer    i;
    logic [7:0] b[$];
    always #12.5 clk_sys_in = ~clk_sys_in;
    arfb_frame_builder #(.AW(4)) u_dut (.clk_sys_in, .srst_in, .pdata_wr_in, .pdata_addr_in,
        .pdata_in, .cmd_req_in, .cmd_id_in, .cmd_name0_in, .cmd_name1_in, .cmd_status_in,
        .cmd_query_in, .cmd_dlen_in, .cmd_busy_out, .stat_req_in, .stat_code_in,
        .stat_pend_out, .tx_data_out, .tx_valid_out, .tx_last_out, .tx_ready_in);
    arfb_host_model u_host (.clk_sys_in, .tx_data_in(tx_data_out), .tx_valid_in(tx_valid_out),
        .tx_last_in(tx_last_out), .tx_ready_out(tx_ready_in), .slow_in(slow));
    task tick(input integer n);
        repeat (n) @(posedge clk_sys_in);
        #1;
    endtask
    task check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        cmp_count = cmp_count + 1;
        if (seen !== exp)
        begin
            fails = fails + 1;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // Wraps a body in delimiter, length and checksum, then compares what the host got.
    task expect_frame(input logic [7:0] body[$]);
        logic [7:0] full[$];
        logic [7:0] cks;
        integer     k;
        full = body;
        cks = 8'hFF;
        for (k = 0; k < body.size(); k++) cks = cks - body[k];
        full.push_front(8'(body.size()));
        full.push_front(8'h00);
        full.push_front(8'h7E);
        full.push_back(cks);
        for (k = 0; k < 400 && u_host.rx_q.size() < full.size(); k++) tick(1);
        check("frame size", 8'(u_host.rx_q.size()), 8'(full.size()));
        if (u_host.rx_q.size() >= full.size())
            for (k = 0; k < full.size(); k++)
            begin
                check("frame byte", u_host.rx_q.pop_front(), full[k]);
                check("frame last", u_host.last_q.pop_front(), 8'(k == full.size() - 1));
            end
    endtask
    task send_cmd(input logic [7:0] id, input logic [7:0] st, input logic q);
        cmd_id_in = id;
        cmd_status_in = st;
        cmd_query_in = q;
        cmd_req_in = 1'b1;
        tick(1);
        cmd_req_in = 1'b0;
        tick(1);
    endtask
    task t_status_codes;
        for (i = 0; i < 5; i++)
        begin
            send_cmd(8'h01, 8'(i), 1'b0);
            expect_frame('{8'h88, 8'h01, 8'h42, 8'h44, 8'(i)});
        end
        $display("set answers done");
    endtask
    task t_query_full;
        for (i = 0; i < 16; i++)
        begin
            pdata_wr_in = 1'b1;
            pdata_addr_in = 4'(i);
            pdata_in = 8'(i * 8'h11);
            tick(1);
        end
        pdata_wr_in = 1'b0;
        b = '{8'h88, 8'h07, 8'h4E, 8'h49, 8'h00};
        for (i = 0; i < 16; i++) b.push_back(8'(i * 8'h11));
        {cmd_name0_in, cmd_name1_in, cmd_dlen_in, slow} = {8'h4E, 8'h49, 5'h10, 1'b1};
        send_cmd(8'h07, 8'h00, 1'b1);
        expect_frame(b);
        {cmd_name0_in, cmd_name1_in, slow} = {8'h42, 8'h44, 1'b0};
        $display("query answer done");
    endtask
    task t_zero_id;
        send_cmd(8'h00, 8'h00, 1'b0);
        tick(30);
        check("busy", cmd_busy_out, 1'b0);
        check("bytes", 8'(u_host.rx_q.size()), 8'h00);
        $display("zero id done");
    endtask
    task t_chain;
        send_cmd(8'h05, 8'h00, 1'b0);
        send_cmd(8'h06, 8'h01, 1'b0);
        for (i = 0; i < 100 && cmd_busy_out; i++) tick(1);
        send_cmd(8'h05, 8'h02, 1'b0);
        expect_frame('{8'h88, 8'h05, 8'h42, 8'h44, 8'h00});
        expect_frame('{8'h88, 8'h05, 8'h42, 8'h44, 8'h02});
        $display("chained answers done");
    endtask
    task t_events;
        logic [7:0] codes[10] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h06, 8'h07, 8'h0D, 8'h11,
            8'h80, 8'hFF};
        integer     j;
        for (j = 0; j < 10; j++)
        begin
            stat_code_in = codes[j];
            stat_req_in = 1'b1;
            tick(1);
            stat_req_in = 1'b0;
            check("pending", stat_pend_out, 1'b1);
            expect_frame('{8'h8A, codes[j]});
        end
        $display("status events done");
    endtask
    // An event and a command in one cycle: the event frame goes out first.
    task t_priority;
        {cmd_id_in, cmd_status_in, stat_code_in, cmd_query_in} = {8'h09, 8'h03, 8'h02, 1'b0};
        cmd_req_in = 1'b1;
        stat_req_in = 1'b1;
        tick(1);
        cmd_req_in = 1'b0;
        stat_req_in = 1'b0;
        expect_frame('{8'h8A, 8'h02});
        expect_frame('{8'h88, 8'h09, 8'h42, 8'h44, 8'h03});
        $display("priority done");
    endtask
    task tally_and_finish;
        $display("comparisons %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    initial
    begin
        tick(4);
        srst_in = 1'b0;
        t_status_codes;
        t_query_full;
        t_zero_id;
        t_chain;
        t_events;
        t_priority;
        tally_and_finish;
    end
    // The whole run needs under five hundred cycles; this cuts a hang short.
    initial
    begin
        #200000;
        fails = fails + 1;
        tally_and_finish;
    end
endmodule
